// ### asp_serial_port.sv
`timescale 1ns/10ps
`include "asp_params.svh"
module asp_serial_port import asp_pkg::*; #(
    parameter int RESET_ONES = `ASP_RESET_ONES,
    // Identification value is arbitrary.
    parameter logic [7:0] ID_CODE = `ASP_ID_DEFAULT
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic conv_done_i,
    input wire logic [23:0] conv_data_i,
    input wire logic upd_warn_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    output logic [15:0] mode_o,
    output logic [15:0] config_o,
    output logic soft_reset_o
);
    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic rst_s1_reg, rst_n;
    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    logic cs_s1_reg, cs_s2_reg, din_s1_reg, din_s2_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s1_reg <= 1'b1;
            sclk_s2_reg <= 1'b1;
            sclk_s3_reg <= 1'b1;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end else if (ce_i) begin
            sclk_s1_reg <= sclk_i;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            cs_s1_reg <= cs_n_i;
            cs_s2_reg <= cs_s1_reg;
            din_s1_reg <= din_i;
            din_s2_reg <= din_s1_reg;
        end
    end

    logic rise, fall, sel;
    assign rise = sclk_s2_reg & ~sclk_s3_reg;
    assign fall = ~sclk_s2_reg & sclk_s3_reg;
    assign sel = ~cs_s2_reg; // R10

    // ************************************************************
    // Interface reset by a run of ones
    // ************************************************************
    // Counting only while selected also covers select tied low.
    logic [5:0] ones_reg;
    logic soft_rst;
    assign soft_rst = rise && sel && din_s2_reg &&
        (ones_reg == 6'(RESET_ONES - 1)); // R9

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ones_reg <= '0;
        end else if (ce_i && rise && sel) begin
            if (!din_s2_reg) begin
                ones_reg <= '0;
            end else if (ones_reg != 6'(RESET_ONES - 1)) begin
                ones_reg <= ones_reg + 6'd1; // R9
            end
        end
    end

    // ************************************************************
    // Transaction sequencer
    // ************************************************************
    asp_state_e state_reg;
    logic [4:0] bitcnt_reg;
    logic [23:0] rx_reg;
    logic [2:0] rs_reg;
    logic [7:0] cmd_byte;
    logic [23:0] in_word;
    logic [4:0] last_bit;
    logic word_end, cmd_end, rd_req, wr_req;

    assign cmd_byte = {rx_reg[6:0], din_s2_reg}; // R11
    assign in_word = {rx_reg[22:0], din_s2_reg};
    assign last_bit = (state_reg == ASP_CMD) ? `ASP_CMD_LAST :
        asp_reg_len(rs_reg) - 5'd1;
    assign word_end = rise && sel && !soft_rst && (bitcnt_reg == last_bit);
    assign cmd_end = word_end && (state_reg == ASP_CMD) &&
        !cmd_byte[`ASP_CB_WEN]; // R11
    assign rd_req = cmd_end && cmd_byte[`ASP_CB_RW];
    assign wr_req = word_end && (state_reg == ASP_WR) &&
        asp_writable(rs_reg);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ASP_CMD;
            bitcnt_reg <= '0;
            rs_reg <= '0;
        end else if (ce_i) begin
            if (soft_rst || !sel) begin
                // Deselect drops a partial word; no half write is kept.
                state_reg <= ASP_CMD; // R9
                bitcnt_reg <= '0;
            end else if (rise) begin
                bitcnt_reg <= word_end ? 5'd0 : bitcnt_reg + 5'd1;
                if (cmd_end) begin
                    rs_reg <= cmd_byte[`ASP_CB_RS_HI:`ASP_CB_RS_LO]; // R6
                    state_reg <= cmd_byte[`ASP_CB_RW] ? ASP_RD : ASP_WR; // R8
                end else if (word_end) begin
                    state_reg <= ASP_CMD; // R8
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_reg <= '0;
        end else if (ce_i && rise && sel) begin
            rx_reg <= in_word; // R5
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    logic wr_en_reg;
    logic [2:0] wr_addr_reg;
    logic [23:0] wr_data_reg;
    logic [7:0] valid_reg;
    logic [15:0] mode_reg, config_reg;
    logic soft_rst_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_en_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
            valid_reg <= '0;
            mode_reg <= '0;
            config_reg <= '0;
            soft_rst_reg <= 1'b0;
        end else if (ce_i) begin
            wr_en_reg <= wr_req;
            soft_rst_reg <= soft_rst;
            if (wr_req) begin
                wr_addr_reg <= rs_reg; // R6
                wr_data_reg <= in_word;
                valid_reg[rs_reg] <= 1'b1;
                if (rs_reg == `ASP_RS_MODE) begin
                    mode_reg <= in_word[15:0];
                end
                if (rs_reg == `ASP_RS_CONFIG) begin
                    config_reg <= in_word[15:0];
                end
            end
            if (soft_rst) begin
                valid_reg <= '0; // R9
                mode_reg <= '0;
                config_reg <= '0;
            end
        end
    end

    logic [23:0] mem_q;
    logic [2:0] rd_rs;
    assign rd_rs = cmd_byte[`ASP_CB_RS_HI:`ASP_CB_RS_LO];

    asp_reg_store #(
        .AW(3),
        .DW(24)
    ) u_store (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .wr_en_i(wr_en_reg),
        .wr_addr_i(wr_addr_reg),
        .wr_data_i(wr_data_reg),
        .rd_en_i(rd_req),
        .rd_addr_i(rd_rs),
        .rd_data_o(mem_q)
    );

    // ************************************************************
    // Conversion result and data ready
    // ************************************************************
    logic rdy_n_reg;
    logic [23:0] data_reg;
    logic data_read_done;
    assign data_read_done = word_end && (state_reg == ASP_RD) &&
        (rs_reg == `ASP_RS_DATA);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdy_n_reg <= 1'b1;
            data_reg <= '0;
        end else if (ce_i) begin
            if (conv_done_i) begin
                // A new result beats a clear landing in the same cycle.
                rdy_n_reg <= 1'b0; // R2
                data_reg <= conv_data_i;
            end else if (upd_warn_i || data_read_done || soft_rst) begin
                rdy_n_reg <= 1'b1; // R3
            end
        end
    end

    // ************************************************************
    // Output shift register and pin
    // ************************************************************
    logic load_pend_reg;
    logic [23:0] tx_reg, rd_word;
    logic dout_reg, oe_n_reg;

    always_comb begin
        unique case (rs_reg)
            `ASP_RS_STATUS: rd_word = {16'h0000, rdy_n_reg, 7'h00};
            `ASP_RS_DATA: rd_word = data_reg;
            `ASP_RS_ID: rd_word = {16'h0000, ID_CODE};
            default: rd_word = valid_reg[rs_reg] ? mem_q : `ASP_REG_DEFAULT;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            load_pend_reg <= 1'b0;
            tx_reg <= '0;
            dout_reg <= 1'b1;
            oe_n_reg <= 1'b1;
        end else if (ce_i) begin
            load_pend_reg <= rd_req;
            oe_n_reg <= cs_s2_reg;
            if (load_pend_reg) begin
                // Left-align so every length leaves MSB first.
                tx_reg <= rd_word << (`ASP_LEN_WORD - asp_reg_len(rs_reg)); // R1
            end else if (state_reg == ASP_RD && fall) begin
                tx_reg <= {tx_reg[22:0], 1'b0}; // R11
            end
            if (state_reg != ASP_RD) begin
                dout_reg <= rdy_n_reg; // R2
            end else if (fall) begin
                dout_reg <= tx_reg[23]; // R4
            end
        end
    end

    assign dout_o = dout_reg;
    assign dout_oe_n_o = oe_n_reg;
    assign mode_o = mode_reg;
    assign config_o = config_reg;
    assign soft_reset_o = soft_rst_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    property p_idle_ready;
        ce_i && state_reg != ASP_RD |=> dout_reg == $past(rdy_n_reg);
    endproperty
    a_idle_ready: assert property (p_idle_ready) // R2
        else $error("dout does not show data ready while idle");

    property p_done_low;
        ce_i && conv_done_i |=> !rdy_n_reg;
    endproperty
    a_done_low: assert property (p_done_low) // R2
        else $error("data ready not low after conversion");

    property p_warn_high;
        ce_i && upd_warn_i && !conv_done_i |=> rdy_n_reg;
    endproperty
    a_warn_high: assert property (p_warn_high) // R3
        else $error("data ready not high before update");

    property p_fall_shift;
        ce_i && state_reg == ASP_RD && fall |=> dout_reg == $past(tx_reg[23]);
    endproperty
    a_fall_shift: assert property (p_fall_shift) // R1
        else $error("output bit not taken from shift register");

    property p_hold_else;
        ce_i && state_reg == ASP_RD && !fall |=> $stable(dout_reg);
    endproperty
    a_hold_else: assert property (p_hold_else) // R4
        else $error("output bit changed away from falling sclk");

    property p_rx_shift;
        ce_i && sel && rise |=> rx_reg[0] == $past(din_s2_reg);
    endproperty
    a_rx_shift: assert property (p_rx_shift) // R5
        else $error("input bit not captured");

    property p_cmd_read;
        ce_i && rd_req |=> state_reg == ASP_RD && rs_reg == $past(rd_rs)
            ##1 load_pend_reg == 1'b0;
    endproperty
    a_cmd_read: assert property (p_cmd_read) // R8
        else $error("read command did not open a read");

    property p_write_commit;
        ce_i && wr_req |=> wr_en_reg && wr_addr_reg == $past(rs_reg)
            && state_reg == ASP_CMD;
    endproperty
    a_write_commit: assert property (p_write_commit) // R6
        else $error("write not routed to selected register");

    property p_soft_reset;
        ce_i && soft_rst |=> state_reg == ASP_CMD && bitcnt_reg == 5'd0
            && soft_rst_reg && valid_reg == 8'h00;
    endproperty
    a_soft_reset: assert property (p_soft_reset) // R9
        else $error("run of ones did not reset the port");

    property p_first_bit;
        ce_i && state_reg == ASP_CMD && word_end && rx_reg[6]
            |=> state_reg == ASP_CMD;
    endproperty
    a_first_bit: assert property (p_first_bit) // R11
        else $error("command with leading bit set was accepted");

    c_read: cover property (ce_i && data_read_done);
    c_write: cover property (ce_i && wr_req);
    c_soft: cover property (ce_i && soft_rst);
    c_ready: cover property (rdy_n_reg ##1 !rdy_n_reg);
endmodule

// ### asp_params.svh
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// What this block does
// R1 - Output shift register, loaded from any register, shifts out on dout.
// R2 - Dout is driven low as data ready once a conversion completes.
// R3 - Unread result: data ready returns high before the next update.
// R4 - Output bits change on falling sclk; host samples on next rising.
// R5 - Bits on the serial input fill an input shift register.
// R6 - Assembled input word goes to the register the last command selected, if that register is writable.
// R7 - Host may use the falling data-ready edge as a result interrupt.
// R8 - Each transaction opens with a command byte, then one access.
// R9 - Thirty-two or more ones on the input reset the port, all but the held conversion result.
// R10 - Host holds select low to address us; select may be tied low.
// R11 - Words travel MSB first; comm_first_bit leads the command byte.

// ************************************************************
// Command byte fields
// ************************************************************
`define ASP_CMD_LAST 5'd7
`define ASP_CB_WEN 7
`define ASP_CB_RW 6
`define ASP_CB_RS_HI 5
`define ASP_CB_RS_LO 3

// ************************************************************
// Register indices and lengths in bits
// ************************************************************
`define ASP_RS_STATUS 3'd0
`define ASP_RS_MODE 3'd1
`define ASP_RS_CONFIG 3'd2
`define ASP_RS_DATA 3'd3
`define ASP_RS_ID 3'd4
`define ASP_RS_OFFSET 3'd6
`define ASP_RS_FSCALE 3'd7
`define ASP_LEN_BYTE 5'd8
`define ASP_LEN_HALF 5'd16
`define ASP_LEN_WORD 5'd24
`define ASP_WORD_W 24
`define ASP_REG_DEFAULT 24'h00_0000
`define ASP_ID_DEFAULT 8'h5a

// ************************************************************
// Interface reset
// ************************************************************
`define ASP_RESET_ONES 32
`endif

// ### asp_pkg.sv
`include "asp_params.svh"
package asp_pkg;
    typedef enum logic [2:0] {
        ASP_CMD = 3'b001,
        ASP_WR = 3'b010,
        ASP_RD = 3'b100
    } asp_state_e;

    function automatic logic [4:0] asp_reg_len(input logic [2:0] rs);
        case (rs)
            `ASP_RS_MODE, `ASP_RS_CONFIG: asp_reg_len = `ASP_LEN_HALF;
            `ASP_RS_DATA, `ASP_RS_OFFSET,
            `ASP_RS_FSCALE: asp_reg_len = `ASP_LEN_WORD;
            default: asp_reg_len = `ASP_LEN_BYTE;
        endcase
    endfunction

    function automatic logic asp_writable(input logic [2:0] rs);
        asp_writable = (rs == `ASP_RS_MODE) || (rs == `ASP_RS_CONFIG) ||
            (rs == `ASP_RS_OFFSET) || (rs == `ASP_RS_FSCALE);
    endfunction
endpackage

// ### asp_reg_store.sv
`timescale 1ns/10ps
module asp_reg_store #(
    parameter int AW = 3,
    parameter int DW = 24
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);
    // The array has no reset; the port tracks which words hold real data.
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else if (ce_i && rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule

// ### asp_host_model.sv
`timescale 1ns/10ps
module asp_host_model #(
    parameter int HALF_CLKS = 6
) (
    input wire logic clk_i,
    input wire logic dout_i,
    input wire logic dout_oe_n_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    output logic line_o
);
    // ************************************************************
    // Shared output line
    // ************************************************************
    // The board holds a pull-up on the shared line, so a released pin reads 1.
    assign line_o = dout_oe_n_i ? 1'b1 : dout_i;

    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end

    // ************************************************************
    // Host side of the serial link
    // ************************************************************
    task automatic wait_clks(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic select(input logic on);
        @(posedge clk_i);
        cs_n_o <= ~on;
        if (!on) begin
            // A released input must not keep showing the last bit.
            din_o <= ~din_o;
        end
        wait_clks(HALF_CLKS);
    endtask

    // The serial clock idles high and stands still outside frames.
    task automatic shift(input int nbits, input logic [23:0] tx,
                         output logic [23:0] rx);
        rx = 24'h00_0000;
        for (int i = nbits - 1; i >= 0; i--) begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            din_o <= tx[i];
            wait_clks(HALF_CLKS - 1);
            @(posedge clk_i);
            rx = {rx[22:0], line_o};
            sclk_o <= 1'b1;
            wait_clks(HALF_CLKS);
        end
    endtask
endmodule

// ### tb_adc_serial_port_ready_pin.sv
`timescale 1ns/10ps
module tb_adc_serial_port_ready_pin;
    localparam int ONES = 8;
    // Identification value is arbitrary.
    localparam logic [7:0] ID_VAL = 8'h3c;
    logic clk;
    logic reset_n = 1'b0;
    logic conv_done = 1'b0;
    logic [23:0] conv_data = 24'h00_0000;
    logic upd_warn = 1'b0;
    logic ce = 1'b1;
    logic sclk, cs_n, din, dout, dout_oe_n, soft_reset, line;
    logic [15:0] mode, cfg;
    logic [23:0] rx;
    int num_errors = 0;
    int cmp_count = 0;
    int sr_seen = 0;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    asp_serial_port #(.RESET_ONES(ONES), .ID_CODE(ID_VAL)) u_asp_serial_port (
        .clk_i(clk), .reset_n_i(reset_n), .ce_i(ce), .sclk_i(sclk),
        .cs_n_i(cs_n), .din_i(din), .conv_done_i(conv_done),
        .conv_data_i(conv_data), .upd_warn_i(upd_warn), .dout_o(dout),
        .dout_oe_n_o(dout_oe_n), .mode_o(mode), .config_o(cfg),
        .soft_reset_o(soft_reset));

    asp_host_model u_asp_host_model (
        .clk_i(clk), .dout_i(dout), .dout_oe_n_i(dout_oe_n), .sclk_o(sclk),
        .cs_n_o(cs_n), .din_o(din), .line_o(line));

    always @(posedge clk) begin
        if (soft_reset === 1'b1) begin
            sr_seen++;
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic xfer(input logic [7:0] cmd, input int n,
                        input logic [23:0] tx, input logic keep);
        logic [23:0] junk;
        u_asp_host_model.select(1'b1);
        u_asp_host_model.shift(8, {16'h0000, cmd}, junk);
        u_asp_host_model.shift(n, tx, rx);
        if (!keep) begin
            u_asp_host_model.select(1'b0);
        end
    endtask

    task automatic pulse(input logic warn, input logic [23:0] d);
        @(posedge clk);
        conv_done <= ~warn;
        upd_warn <= warn;
        conv_data <= d;
        @(posedge clk);
        conv_done <= 1'b0;
        upd_warn <= 1'b0;
    endtask

    // A line level that never arrives ends the run.
    task automatic wait_line(input logic lvl, input int bound);
        int k;
        k = 0;
        while (line !== lvl && k < bound) begin
            @(posedge clk);
            k++;
        end
        check("ready line", {23'h0, line}, {23'h0, lvl});
        if (line !== lvl) begin
            wrap_up();
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_reset();
        check("dout", {23'h0, dout}, 24'h00_0001); // RESET
        check("dout enable", {23'h0, dout_oe_n}, 24'h00_0001); // RESET
        check("mode", {8'h0, mode}, 24'h00_0000); // RESET
        check("config", {8'h0, cfg}, 24'h00_0000); // RESET
        check("soft reset", {23'h0, soft_reset}, 24'h00_0000); // RESET
        $display("test_reset done");
    endtask

    task automatic test_write_read();
        xfer(8'h08, 16, 24'h00_1234, 1'b0);
        check("mode", {8'h0, mode}, 24'h00_1234);
        xfer(8'h10, 16, 24'h00_a5c3, 1'b0);
        check("config", {8'h0, cfg}, 24'h00_a5c3);
        check("mode kept", {8'h0, mode}, 24'h00_1234);
        xfer(8'h48, 16, 24'h00_0000, 1'b0);
        check("mode read", rx, 24'h00_1234);
        xfer(8'h50, 16, 24'h00_0000, 1'b0);
        check("config read", rx, 24'h00_a5c3);
        xfer(8'h30, 24, 24'h12_3456, 1'b0);
        xfer(8'h70, 24, 24'h00_0000, 1'b0);
        check("offset read", rx, 24'h12_3456);
        $display("test_write_read done");
    endtask

    task automatic test_ready();
        u_asp_host_model.select(1'b1);
        wait_line(1'b1, 8);
        check("dout enable", {23'h0, dout_oe_n}, 24'h00_0000);
        pulse(1'b0, 24'hab_cdef);
        wait_line(1'b0, 6);
        xfer(8'h40, 8, 24'h00_0000, 1'b1);
        check("status ready", rx, 24'h00_0000);
        xfer(8'h58, 24, 24'h00_0000, 1'b1);
        check("data read", rx, 24'hab_cdef);
        wait_line(1'b1, 6);
        pulse(1'b0, 24'h00_0123);
        wait_line(1'b0, 6);
        pulse(1'b1, 24'h00_0000);
        wait_line(1'b1, 6);
        xfer(8'h40, 8, 24'h00_0000, 1'b0);
        check("status idle", rx, 24'h00_0080);
        $display("test_ready done");
    endtask

    task automatic test_refused();
        logic [23:0] junk;
        u_asp_host_model.select(1'b1);
        u_asp_host_model.shift(8, 24'h00_0088, junk);
        xfer(8'h08, 16, 24'h00_0f0f, 1'b0);
        check("mode after bad command", {8'h0, mode}, 24'h00_0f0f);
        xfer(8'h20, 8, 24'h00_00f0, 1'b0);
        xfer(8'h60, 8, 24'h00_0000, 1'b0);
        check("id read", rx, {16'h0, ID_VAL});
        xfer(8'h18, 24, 24'h00_7777, 1'b0);
        xfer(8'h58, 24, 24'h00_0000, 1'b0);
        check("data kept", rx, 24'h00_0123);
        $display("test_refused done");
    endtask

    task automatic test_abort();
        logic [23:0] junk;
        u_asp_host_model.select(1'b1);
        u_asp_host_model.shift(8, 24'h00_0008, junk);
        u_asp_host_model.shift(8, 24'h00_0099, junk);
        u_asp_host_model.select(1'b0);
        xfer(8'h10, 16, 24'h00_3c3c, 1'b0);
        check("config after abort", {8'h0, cfg}, 24'h00_3c3c);
        check("mode after abort", {8'h0, mode}, 24'h00_0f0f);
        $display("test_abort done");
    endtask

    task automatic test_iface_reset();
        logic [23:0] junk;
        sr_seen = 0;
        u_asp_host_model.select(1'b1);
        u_asp_host_model.shift(ONES, 24'hff_ffff, junk);
        u_asp_host_model.select(1'b0);
        check("soft reset pulses", 24'(sr_seen), 24'h00_0001);
        check("mode cleared", {8'h0, mode}, 24'h00_0000);
        check("config cleared", {8'h0, cfg}, 24'h00_0000);
        xfer(8'h08, 16, 24'h00_0042, 1'b0);
        check("mode after reset", {8'h0, mode}, 24'h00_0042);
        xfer(8'h70, 24, 24'h00_0000, 1'b0);
        check("offset cleared", rx, 24'h00_0000);
        $display("test_iface_reset done");
    endtask

    // With the enable low, neither a result nor a write may land.
    task automatic test_freeze();
        @(posedge clk);
        ce <= 1'b0;
        pulse(1'b0, 24'h00_0555);
        xfer(8'h08, 16, 24'h00_7e7e, 1'b0);
        check("mode frozen", {8'h0, mode}, 24'h00_0042);
        @(posedge clk);
        ce <= 1'b1;
        xfer(8'h40, 8, 24'h00_0000, 1'b0);
        check("status after freeze", rx, 24'h00_0080);
        $display("test_freeze done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        test_reset();
        test_write_read();
        test_ready();
        test_refused();
        test_abort();
        test_iface_reset();
        test_freeze();
        wrap_up();
    end
endmodule
